// >>> hdl/rmw_unit_pkg.sv
package rmw_unit_pkg;

  localparam int DATA_W = 32;
  localparam int OFS_W  = 16;
  localparam int HINT_W = 5;
  localparam int GPR_W  = 5;

  localparam logic [1:0] ALIGN_ZERO = 2'h0;

  typedef enum logic [1:0] {
    OP_LOAD_LINKED,
    OP_STORE_COND,
    OP_PREFETCH
  } op_kind_t;

  // Exception codes reported to the core's exception logic
  localparam logic [2:0] EXC_NONE      = 3'h0;
  localparam logic [2:0] EXC_ADDR_LOAD = 3'h1;
  localparam logic [2:0] EXC_ADDR_STOR = 3'h2;
  localparam logic [2:0] EXC_BUS       = 3'h3;

  // Prefetch hint encodings
  localparam logic [4:0] HINT_LOAD      = 5'h00;
  localparam logic [4:0] HINT_STORE     = 5'h01;
  localparam logic [4:0] HINT_LOAD_STR  = 5'h04;
  localparam logic [4:0] HINT_STORE_STR = 5'h05;
  localparam logic [4:0] HINT_LOAD_RET  = 5'h06;
  localparam logic [4:0] HINT_STORE_RET = 5'h07;
  localparam logic [4:0] HINT_WB_INV    = 5'h19;

  // Memory operation kinds on the SRAM-style port
  localparam logic [1:0] MOP_READ   = 2'h0;
  localparam logic [1:0] MOP_WRITE  = 2'h1;
  localparam logic [1:0] MOP_PF     = 2'h2;
  localparam logic [1:0] MOP_WB_INV = 2'h3;

  localparam logic [DATA_W-1:0] SC_PASS = 32'h0000_0001;
  localparam logic [DATA_W-1:0] SC_FAIL = 32'h0000_0000;

endpackage : rmw_unit_pkg

// >>> hdl/rmw_unit.sv
`timescale 1ns/1ps
module rmw_unit (
  input  wire logic                           core_clk,
  input  wire logic                           reset_n,
  input  wire logic                           op_valid,
  input  wire rmw_unit_pkg::op_kind_t         op_kind,
  input  wire logic [rmw_unit_pkg::DATA_W-1:0] base_val,
  input  wire logic [rmw_unit_pkg::OFS_W-1:0]  offset,
  input  wire logic [rmw_unit_pkg::DATA_W-1:0] store_val,
  input  wire logic [rmw_unit_pkg::GPR_W-1:0]  target_gpr,
  input  wire logic [rmw_unit_pkg::HINT_W-1:0] hint,
  input  wire logic                           xlat_uncached,
  input  wire logic                           xlat_mapped,
  input  wire logic                           xlat_tlb_hit,
  input  wire logic                           line_locked,
  input  wire logic [2:0]                     coherency_attr,
  input  wire logic                           exception_return,
  input  wire logic                           exception_taken,
  input  wire logic                           mem_ack,
  input  wire logic [rmw_unit_pkg::DATA_W-1:0] mem_rdata,
  input  wire logic                           mem_lock_fail,
  input  wire logic                           mem_err,
  output logic                                op_ready,
  output logic                                mem_req,
  output logic [1:0]                          mem_op,
  output logic                                mem_lock,
  output logic [rmw_unit_pkg::DATA_W-1:0]      mem_addr,
  output logic [rmw_unit_pkg::DATA_W-1:0]      mem_wdata,
  output logic [2:0]                          mem_cca,
  output logic                                wb_valid,
  output logic [rmw_unit_pkg::GPR_W-1:0]       wb_gpr,
  output logic [rmw_unit_pkg::DATA_W-1:0]      wb_data,
  output logic                                exc_valid,
  output logic [2:0]                          exc_code,
  output logic                                link_flag
);

  ////////////////////////////////////////////////////////////////////////////

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEM
  } fsm_t;

  typedef struct packed {
    fsm_t                          fsm;
    rmw_unit_pkg::op_kind_t          kind;
    logic                          link;
    logic                          req;
    logic [1:0]                    mop;
    logic                          lock;
    logic [rmw_unit_pkg::DATA_W-1:0] addr;
    logic [rmw_unit_pkg::DATA_W-1:0] wdata;
    logic [2:0]                    cca;
    logic                          wbv;
    logic [rmw_unit_pkg::GPR_W-1:0]  gpr;
    logic [rmw_unit_pkg::DATA_W-1:0] wbd;
    logic                          excv;
    logic [2:0]                    exc;
    logic                          rdy;
  } state_t;

  state_t s_reg;
  state_t s_next;

  function automatic logic [rmw_unit_pkg::DATA_W-1:0] eff_addr(
    input logic [rmw_unit_pkg::DATA_W-1:0] b,
    input logic [rmw_unit_pkg::OFS_W-1:0]  o
  );
    logic [rmw_unit_pkg::DATA_W-1:0] ext;
    ext = {{(rmw_unit_pkg::DATA_W-rmw_unit_pkg::OFS_W)
            {o[rmw_unit_pkg::OFS_W-1]}}, o};
    return b + ext;
  endfunction : eff_addr

  function automatic logic hint_known(
    input logic [rmw_unit_pkg::HINT_W-1:0] h
  );
    unique case (h)
      rmw_unit_pkg::HINT_LOAD,
      rmw_unit_pkg::HINT_STORE,
      rmw_unit_pkg::HINT_LOAD_STR,
      rmw_unit_pkg::HINT_STORE_STR,
      rmw_unit_pkg::HINT_LOAD_RET,
      rmw_unit_pkg::HINT_STORE_RET,
      rmw_unit_pkg::HINT_WB_INV: return 1'b1;
      default:                   return 1'b0;
    endcase
  endfunction : hint_known

  logic [rmw_unit_pkg::DATA_W-1:0] ea;
  logic                            misaligned;
  assign ea         = eff_addr(base_val, offset);
  assign misaligned = ea[1:0] != rmw_unit_pkg::ALIGN_ZERO;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_next      = s_reg;
    s_next.wbv  = 1'b0;
    s_next.excv = 1'b0;
    s_next.exc  = rmw_unit_pkg::EXC_NONE;
    // An exception or return from one drops the reservation, unless a load-linked completes in the same cycle
    if (exception_return) begin
      s_next.link = 1'b0;
    end
    if (exception_taken) begin
      s_next.link = 1'b0;
    end
    unique case (s_reg.fsm)
      ST_IDLE: begin
        if (op_valid) begin
          s_next.kind  = op_kind;
          s_next.gpr   = target_gpr;
          s_next.addr  = ea;
          s_next.wdata = store_val;
          s_next.cca   = coherency_attr;
          unique case (op_kind)
            rmw_unit_pkg::OP_LOAD_LINKED: begin
              if (misaligned) begin
                s_next.excv = 1'b1;
                s_next.exc  = rmw_unit_pkg::EXC_ADDR_LOAD;
              end else begin
                s_next.req = 1'b1;
                s_next.mop = rmw_unit_pkg::MOP_READ;
                s_next.fsm = ST_MEM;
              end
            end
            rmw_unit_pkg::OP_STORE_COND: begin
              if (misaligned) begin
                s_next.excv = 1'b1;
                s_next.exc  = rmw_unit_pkg::EXC_ADDR_STOR;
              end else if (!s_reg.link || exception_return
                           || exception_taken) begin
                // No reservation: fail without touching memory
                s_next.wbv  = 1'b1;
                s_next.wbd  = rmw_unit_pkg::SC_FAIL;
                s_next.link = 1'b0;
              end else begin
                s_next.req  = 1'b1;
                s_next.lock = 1'b1;
                s_next.mop  = rmw_unit_pkg::MOP_WRITE;
                s_next.fsm  = ST_MEM;
              end
            end
            default: begin
              // Prefetch: address faults dropped, nothing reported; a bus error is reported as EXC_BUS
              // Intervening prefetch leaves the reservation intact
              if (!misaligned && !xlat_uncached && !line_locked
                  && (!xlat_mapped || xlat_tlb_hit)
                  && hint_known(hint)) begin
                s_next.req = 1'b1;
                s_next.mop = (hint == rmw_unit_pkg::HINT_WB_INV)
                           ? rmw_unit_pkg::MOP_WB_INV
                           : rmw_unit_pkg::MOP_PF;
                s_next.fsm = ST_MEM;
              end
            end
          endcase
        end
      end
      ST_MEM: begin
        if (mem_ack) begin
          s_next.req  = 1'b0;
          s_next.lock = 1'b0;
          s_next.fsm  = ST_IDLE;
          unique case (s_reg.kind)
            rmw_unit_pkg::OP_LOAD_LINKED: begin
              s_next.wbv = 1'b1;
              s_next.wbd = mem_rdata;
              // New reservation replaces the old; no snoop
              // output exists, so other cores are unaffected
              s_next.link = 1'b1;
            end
            rmw_unit_pkg::OP_STORE_COND: begin
              s_next.wbv  = 1'b1;
              // Store already issued: only the lock decides the result
              s_next.wbd  = mem_lock_fail
                          ? rmw_unit_pkg::SC_FAIL
                          : rmw_unit_pkg::SC_PASS;
              s_next.link = 1'b0;
            end
            default: begin
              if (mem_err) begin
                s_next.excv = 1'b1;
                s_next.exc  = rmw_unit_pkg::EXC_BUS;
              end
            end
          endcase
        end
      end
      default: s_next.fsm = ST_IDLE;
    endcase
    s_next.rdy = s_next.fsm == ST_IDLE;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg      <= '0;
      s_reg.fsm  <= ST_IDLE;
      s_reg.kind <= rmw_unit_pkg::OP_LOAD_LINKED;
      s_reg.rdy  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign op_ready  = s_reg.rdy;
  assign mem_req   = s_reg.req;
  assign mem_op    = s_reg.mop;
  assign mem_lock  = s_reg.lock;
  assign mem_addr  = s_reg.addr;
  assign mem_wdata = s_reg.wdata;
  assign mem_cca   = s_reg.cca;
  assign wb_valid  = s_reg.wbv;
  assign wb_gpr    = s_reg.gpr;
  assign wb_data   = s_reg.wbd;
  assign exc_valid = s_reg.excv;
  assign exc_code  = s_reg.exc;
  assign link_flag = s_reg.link;

  ////////////////////////////////////////////////////////////////////////////

  AST_MISALIGN_NO_ACCESS: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && misaligned
      && op_kind != rmw_unit_pkg::OP_PREFETCH
      |=> exc_valid && !mem_req)
    else $error("misaligned access not trapped");

  AST_PF_NO_EXC_ADDR: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_PREFETCH
      |=> !exc_valid)
    else $error("prefetch raised exception");

  AST_PF_MISALIGN_DROP: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_PREFETCH
      && misaligned |=> !mem_req)
    else $error("faulting prefetch issued memory op");

  AST_PF_UNCACHED: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_PREFETCH
      && xlat_uncached |=> !mem_req)
    else $error("uncached prefetch issued memory op");

  AST_PF_LOCKED: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_PREFETCH
      && line_locked |=> !mem_req)
    else $error("prefetch touched locked line");

  AST_PF_TLB_MISS: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_PREFETCH
      && xlat_mapped && !xlat_tlb_hit |=> !mem_req)
    else $error("prefetch moved data without translation");

  AST_LL_SETS_LINK: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    mem_req && mem_ack && !exception_return && !exception_taken
      && mem_op == rmw_unit_pkg::MOP_READ
      |=> link_flag && wb_valid && wb_data == $past(mem_rdata))
    else $error("load-linked did not set link flag");

  AST_SC_NO_LINK_FAIL: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_STORE_COND
      && !misaligned && !link_flag
      |=> wb_valid && wb_data == rmw_unit_pkg::SC_FAIL && !mem_req)
    else $error("store without reservation did not fail");

  AST_SC_LOCK_RESULT: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    mem_req && mem_ack && mem_lock
      |=> wb_valid && !link_flag
        && (wb_data == rmw_unit_pkg::SC_FAIL) == $past(mem_lock_fail))
    else $error("lock outcome not reported");

  AST_EXCEPTION_RETURN_CLEARS: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    exception_return && !(mem_req && mem_ack && !mem_lock
      && mem_op == rmw_unit_pkg::MOP_READ) |=> !link_flag)
    else $error("exception return kept reservation");

  AST_PF_RESERVED_HINT: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_PREFETCH
      && !hint_known(hint) |=> !mem_req)
    else $error("reserved prefetch hint issued memory op");

  AST_PF_WB_INV_OP: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_PREFETCH
      && !misaligned && !xlat_uncached && !line_locked
      && (!xlat_mapped || xlat_tlb_hit) && hint == rmw_unit_pkg::HINT_WB_INV
      |=> mem_req && mem_op == rmw_unit_pkg::MOP_WB_INV)
    else $error("writeback-invalidate hint not issued");

  AST_PF_KEEPS_LINK: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_PREFETCH
      && !exception_return && !exception_taken
      |=> link_flag == $past(link_flag))
    else $error("prefetch changed reservation");

  AST_CCA_FOLLOWS: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready |=> mem_cca == $past(coherency_attr))
    else $error("memory attribute not taken from address");

  AST_LL_ISSUE: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_LOAD_LINKED
      && !misaligned |=> mem_req && mem_op == rmw_unit_pkg::MOP_READ
        && mem_addr == $past(ea))
    else $error("load-linked read not issued at address");

  AST_SC_ISSUE: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_STORE_COND
      && !misaligned && link_flag && !exception_return && !exception_taken
      |=> mem_req && mem_lock && mem_op == rmw_unit_pkg::MOP_WRITE
        && mem_wdata == $past(store_val))
    else $error("conditional store not issued locked");

  AST_EXC_CLEARS: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    exception_taken && !(mem_req && mem_ack
      && mem_op == rmw_unit_pkg::MOP_READ) |=> !link_flag)
    else $error("exception kept reservation");

  AST_REQ_HELD: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
      && $stable(mem_op) && $stable(mem_wdata) && $stable(mem_lock))
    else $error("memory request changed before acknowledge");

  AST_LL_EXC_CODE: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_LOAD_LINKED
      && misaligned |=> exc_code == rmw_unit_pkg::EXC_ADDR_LOAD)
    else $error("load-linked raised wrong exception");

  AST_SC_EXC_CODE: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    op_valid && op_ready && op_kind == rmw_unit_pkg::OP_STORE_COND
      && misaligned |=> exc_code == rmw_unit_pkg::EXC_ADDR_STOR)
    else $error("conditional store raised wrong exception");

endmodule : rmw_unit

// >>> tb/mem_partner.sv
`timescale 1ns/1ps
module mem_partner (
  input  wire logic        core_clk,
  input  wire logic        mem_req,
  input  wire logic [1:0]  mem_op,
  input  wire logic        mem_lock,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  delay,
  input  wire logic        fail_next,
  input  wire logic        err_next,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output logic             mem_lock_fail,
  output logic             mem_err
);
  logic [31:0] store [logic [31:0]];
  int          wait_cnt = 0;
  initial {mem_ack, mem_rdata, mem_lock_fail, mem_err} = 35'h0;
  always @(negedge core_clk) begin
    // Idle read bus keeps changing so a stale capture cannot match
    mem_rdata     <= ~mem_rdata;
    mem_ack       <= 1'b0;
    mem_lock_fail <= 1'b0;
    mem_err       <= 1'b0;
    if (mem_req && !mem_ack) begin
      if (wait_cnt < delay) wait_cnt <= wait_cnt + 1;
      else begin
        wait_cnt      <= 0;
        mem_ack       <= 1'b1;
        mem_rdata     <= store.exists(mem_addr) ? store[mem_addr] : ~mem_addr;
        mem_lock_fail <= mem_lock && fail_next;
        mem_err       <= err_next;
        if (mem_op == rmw_unit_pkg::MOP_WRITE && !(mem_lock && fail_next))
          store[mem_addr] = mem_wdata;
      end
    end
  end
endmodule : mem_partner

// >>> tb/atomic_rmw_and_prefetch_unit_test.sv
`timescale 1ns/1ps
module atomic_rmw_and_prefetch_unit_test;
  logic core_clk = 1'b0, reset_n = 1'b0, op_valid = 1'b0;
  rmw_unit_pkg::op_kind_t op_kind = rmw_unit_pkg::OP_LOAD_LINKED;
  logic [31:0] base_val = 32'h0, store_val = 32'h0, b, ea;
  logic [15:0] offset = 16'h0, o;
  logic [4:0]  target_gpr = 5'h0, hint = 5'h0, wb_gpr, got_gpr;
  logic [3:0]  at = 4'h0;
  logic        xlat_uncached, xlat_mapped, xlat_tlb_hit, line_locked;
  logic [2:0]  coherency_attr = 3'h0, mem_cca, exc_code, got_cca, got_code;
  logic        exception_return = 1'b0, exception_taken = 1'b0;
  logic        fail_next = 1'b0, err_next = 1'b0, pf_ok;
  logic [1:0]  delay = 2'h0, mem_op, got_op;
  logic        mem_ack, mem_lock_fail, mem_err, op_ready, mem_req, mem_lock;
  logic        wb_valid, exc_valid, link_flag, saw_req, saw_wb, saw_exc;
  logic        got_lock;
  logic [31:0] mem_rdata, mem_addr, mem_wdata, wb_data;
  logic [31:0] got_addr, got_wdata, got_data, seed;
  logic [31:0] ref_mem [logic [31:0]];
  logic [3:0]  atab [6] = '{4'hE, 4'hA, 4'h4, 4'h7, 4'h6, 4'h0};
  int          n_errors = 0, total_checks = 0;
  assign {xlat_uncached, xlat_mapped, xlat_tlb_hit, line_locked} = at;

  initial forever #4 core_clk = ~core_clk;

  rmw_unit dut (.core_clk, .reset_n, .op_valid, .op_kind, .base_val,
    .offset, .store_val, .target_gpr, .hint, .xlat_uncached, .xlat_mapped,
    .xlat_tlb_hit, .line_locked, .coherency_attr, .exception_return,
    .exception_taken, .mem_ack, .mem_rdata, .mem_lock_fail, .mem_err,
    .op_ready, .mem_req, .mem_op, .mem_lock, .mem_addr, .mem_wdata,
    .mem_cca, .wb_valid, .wb_gpr, .wb_data, .exc_valid, .exc_code,
    .link_flag);
  mem_partner mem (.core_clk, .mem_req, .mem_op, .mem_lock, .mem_addr,
    .mem_wdata, .delay, .fail_next, .err_next, .mem_ack, .mem_rdata,
    .mem_lock_fail, .mem_err);

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // One request, then a bounded watch of every answer it produces
  task automatic op(input rmw_unit_pkg::op_kind_t k, input logic [15:0] ofs,
                    input logic [4:0] h, input logic [3:0] a);
    @(negedge core_clk);
    op_valid = 1'b1;
    op_kind = k;
    {base_val, offset, hint, at} = {b, ofs, h, a};
    {store_val, target_gpr, coherency_attr} = {$urandom, 8'($urandom)};
    delay = 2'($urandom);
    {saw_req, saw_wb, saw_exc} = 3'h0;
    @(negedge core_clk);
    op_valid = 1'b0;
    repeat (12) begin
      if (mem_req) {saw_req, got_op, got_lock, got_addr, got_wdata, got_cca}
        = {1'b1, mem_op, mem_lock, mem_addr, mem_wdata, mem_cca};
      if (wb_valid) {saw_wb, got_gpr, got_data} = {1'b1, wb_gpr, wb_data};
      if (exc_valid) {saw_exc, got_code} = {1'b1, exc_code};
      @(negedge core_clk);
    end
    if (op_ready !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : op

  task automatic ll(input logic [3:0] a);
    ea = b + {{16{o[15]}}, o};
    op(rmw_unit_pkg::OP_LOAD_LINKED, o, 5'h00, a);
    chk({saw_req, saw_wb, got_gpr}, {2'h3, target_gpr});
    chk(got_addr, ea);
    chk(got_op, rmw_unit_pkg::MOP_READ);
    chk(got_data, ref_mem.exists(ea) ? ref_mem[ea] : ~ea);
    chk(got_cca, coherency_attr);
    chk(link_flag, 1'b1);
  endtask : ll

  task automatic sc(input logic ok, input logic fail);
    ea = b + {{16{o[15]}}, o};
    fail_next = fail;
    op(rmw_unit_pkg::OP_STORE_COND, o, 5'h00, 4'h0);
    chk({saw_req, saw_wb}, {ok, 1'b1});
    chk(got_data, ok && !fail);
    if (ok) begin
      chk({got_lock, got_addr}, {1'b1, ea});
      chk(got_wdata, store_val);
      if (!fail) ref_mem[ea] = store_val;
    end
    chk(link_flag, 1'b0);
  endtask : sc

  //////////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(54208);
    repeat (5) @(negedge core_clk);
    reset_n = 1'b1;
    chk(link_flag, 1'b0);
    for (int i = 0; i < 6; i++) begin
      b = $urandom & 32'hFFFF_FFFC;
      o = 16'($urandom) & 16'hFFFC;
      ll({i[0], 3'h0});
      sc(1'b1, i[1]);
      ll(4'h0);
    end
    $display("test link_and_store done");
    for (int j = 0; j < 2; j++) begin
      ll(4'h0);
      @(negedge core_clk);
      {exception_return, exception_taken} = j[0] ? 2'b01 : 2'b10;
      @(negedge core_clk);
      {exception_return, exception_taken} = 2'b00;
      chk(link_flag, 1'b0);
      sc(1'b0, 1'b0);
    end
    $display("test kill_reservation done");
    for (int k = 1; k < 4; k++) begin
      op(k[0] ? rmw_unit_pkg::OP_LOAD_LINKED : rmw_unit_pkg::OP_STORE_COND,
         o + 16'(k), 5'h00, 4'h0);
      chk({saw_req, saw_exc, got_code}, {2'h1, k[0] ?
          rmw_unit_pkg::EXC_ADDR_LOAD : rmw_unit_pkg::EXC_ADDR_STOR});
    end
    $display("test misaligned done");
    for (int h = 0; h < 32; h++) begin
      op(rmw_unit_pkg::OP_PREFETCH, o, 5'(h), 4'h6);
      pf_ok = h inside {0, 1, 4, 5, 6, 7, 25};
      chk({saw_req, saw_exc}, {pf_ok, 1'b0});
      if (pf_ok) chk(got_op, h == 25 ? rmw_unit_pkg::MOP_WB_INV :
                     rmw_unit_pkg::MOP_PF);
      if (pf_ok) chk({got_cca, got_addr}, {coherency_attr, ea});
    end
    foreach (atab[n]) begin
      op(rmw_unit_pkg::OP_PREFETCH, o + 16'(n == 4), 5'h00, atab[n]);
      chk({saw_req, saw_exc}, {n == 5, 1'b0});
    end
    err_next = 1'b1;
    op(rmw_unit_pkg::OP_PREFETCH, o, rmw_unit_pkg::HINT_STORE, 4'h6);
    err_next = 1'b0;
    chk({saw_exc, got_code}, {1'b1, rmw_unit_pkg::EXC_BUS});
    $display("test prefetch done");
    tally_and_finish();
  end
endmodule : atomic_rmw_and_prefetch_unit_test
